// ---- port_pin_pkg.sv ----
// Shared constants and types for the port pin function multiplexer.
//======================================================================
// Summary of operation
// R1 - Port 1 bits 2 and 3 only ever pull low when used as outputs, never drive high.
// R2 - The port 1 bit 2 pad carries the timer 0 count input or its open-drain overflow output.
// R3 - Port 1 bit 3 also feeds external interrupt 0 and carries I2C data; bit 2 carries I2C clock.
// R4 - Port 1 bit 5 is an input only and has no output driver at all.
// R5 - When the shared pad is the reset input (always at power-on, else if selected), low resets.
// R6 - The reset pad is sampled at the end of power-on to force in-system programming mode.
// R7 - Port 2 has 4 bits and during reset they are input-only with the pull-up disabled.
// R8 - Each port 2 pin has its own output type and acts as input or output according to it.
// R9 - Port 2 bit 2 carries SPI MOSI: output as master, input as slave.
// R10 - Port 2 bit 3 carries SPI MISO: input as master, output as slave.
// R11 - Port 2 bit 5 carries the SPI clock, output as master, input as slave; bit 4 is slave select.
// R12 - During reset port 1 is input-only with the pull-up disabled, each pin set up on its own.
// R13 - An enabled alternate function drives a shared pad in place of the port latch.
package port_pin_pkg;

   //======================================================================
   // Port pin output types
   typedef enum logic [1:0]
   {
      mode_quasi      = 2'h0,
      mode_push_pull  = 2'h1,
      mode_input_only = 2'h2,
      mode_open_drain = 2'h3
   } port_mode_e;

   localparam port_mode_e MODE_RST   = mode_input_only;
   localparam int         MODE_W     = 2;

   //======================================================================
   // Port 2 field positions, index 0 is pad bit 2
   localparam int P2_W      = 4;
   localparam int P2_MOSI   = 0;
   localparam int P2_MISO   = 1;
   localparam int P2_SEL    = 2;
   localparam int P2_SCK    = 3;

   //======================================================================
   // Port 1 field positions, index 0 is pad bit 2
   localparam int P1_W      = 2;
   localparam int P1_SCL    = 0;
   localparam int P1_SDA    = 1;

   // Bit of the user configuration byte that hands the shared pad to reset.
   localparam int UCFG_RST_SEL_BIT = 0;

   // Two flip-flops guard every pad input.
   localparam int SYNC_STAGES = 2;

endpackage

// ---- pad_sync.sv ----
// Two flip-flop synchroniser for pad inputs.
`timescale 1ns/1ps
module pad_sync
#(
   parameter int W = 1
)
(
   // Clock and reset
   input  wire logic         sys_clk,
   input  wire logic         nrst,
   // Data
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_ff;

   // The first stage is read by the second stage only. Pads idle high behind
   // their pull-ups, so both stages start high: a low start would look like a
   // reset pad held low for two edges after every reset.
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         meta_ff  <= '1;
         sync_out <= '1;
      end
      else
      begin
         meta_ff  <= async_in;
         sync_out <= meta_ff;
      end
   end

endmodule

// ---- pad_drive.sv ----
// Converts a pin output type and value into pad drive, enable and pull-up.
`timescale 1ns/1ps
module pad_drive
(
   // Configuration
   input  port_pin_pkg::port_mode_e mode,
   input  wire logic                val,
   // Pad controls
   output logic                     out,
   output logic                     oe,
   output logic                     pu
);

   // Quasi-bidirectional pins only pull low and lean on the weak pull-up for
   // the high level; the brief strong high pulse is left out here.
   always_comb
   begin
      out = 1'b0;
      oe  = 1'b0;
      pu  = 1'b0;
      unique case (mode)
         port_pin_pkg::mode_quasi:
         begin
            oe = !val;
            pu = 1'b1;
         end
         port_pin_pkg::mode_push_pull:
         begin
            out = val;
            oe  = 1'b1;
         end
         port_pin_pkg::mode_open_drain:
         begin
            oe = !val;
         end
         port_pin_pkg::mode_input_only:
         begin
            oe = 1'b0;
         end
      endcase
   end

endmodule

// ---- port_pin_function_mux.sv ----
// Pad sharing between port 1/2 bits and timer, interrupt, I2C, SPI and reset.
`timescale 1ns/1ps
module port_pin_function_mux
(
   // Clock and system reset
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   // Power-on and reset pad selection
   input  wire logic       por_active,
   input  wire logic [7:0] user_config_byte_one,
   output logic            dev_rst_n_ff,
   output logic            in_system_programming_mode,
   // Port 1 bit 2 pad
   input  wire logic       port1_bit2_in,
   output logic            port1_bit2_out,
   output logic            port1_bit2_oe,
   // Port 1 bit 3 pad
   input  wire logic       port1_bit3_in,
   output logic            port1_bit3_out,
   output logic            port1_bit3_oe,
   // Port 1 bit 5 pad, input only
   input  wire logic       port1_bit5_in,
   // Port 2 pads, index 0 is bit 2
   input  wire logic [3:0] port2_pad_in,
   output logic      [3:0] port2_pad_out,
   output logic      [3:0] port2_pad_oe,
   output logic      [3:0] port2_pad_pu,
   // Port 1 latches and output types, 1 selects open-drain output
   input  wire logic [1:0] p1_latch,
   input  wire logic [1:0] p1_od_en,
   output logic      [2:0] p1_pin_val,
   // Port 2 latches and output types
   input  wire logic [3:0] p2_latch,
   input  wire logic [7:0] p2_mode,
   output logic      [3:0] p2_pin_val,
   // Timer 0 and interrupt 0
   input  wire logic       t0_out_en,
   input  wire logic       t0_out_val,
   output logic            timer_zero_pin,
   output logic            ext_irq_zero_input,
   // I2C
   input  wire logic       i2c_en,
   input  wire logic       scl_out,
   input  wire logic       sda_out,
   output logic            scl_in,
   output logic            sda_in,
   // SPI
   input  wire logic       spi_en,
   input  wire logic       spi_master,
   input  wire logic       mosi_out,
   input  wire logic       miso_out,
   input  wire logic       sck_out,
   output logic            mosi_in,
   output logic            miso_in,
   output logic            sel_n_in,
   output logic            spi_serial_clock_pad
);

   //======================================================================
   // Pad input synchronisers
   logic [2:0] p1_sync;
   logic [3:0] p2_sync;

   pad_sync #(.W(3)) u_p1_sync
   (
      .sys_clk  (sys_clk),
      .nrst     (nrst),
      .async_in ({port1_bit5_in, port1_bit3_in, port1_bit2_in}),
      .sync_out (p1_sync)
   );

   pad_sync #(.W(port_pin_pkg::P2_W)) u_p2_sync
   (
      .sys_clk  (sys_clk),
      .nrst     (nrst),
      .async_in (port2_pad_in),
      .sync_out (p2_sync)
   );

   //======================================================================
   // Reset pad and programming mode entry
   logic rst_sel;
   logic rst_pad_low;
   logic rst_act;
   logic por_q_ff;

   assign rst_sel     = por_active || user_config_byte_one[port_pin_pkg::UCFG_RST_SEL_BIT];
   assign rst_pad_low = rst_sel && !p1_sync[2]; // R5
   assign rst_act     = !nrst || rst_pad_low; // R5

   // The registered reset also covers the core and peripherals outside.
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         dev_rst_n_ff <= 1'b0;
      else
         dev_rst_n_ff <= !rst_pad_low; // R5
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         por_q_ff <= 1'b0;
      else
         por_q_ff <= por_active;
   end

   // The pad level is caught as power-on ends; it holds until nrst clears it or the next power-on ends.
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         in_system_programming_mode <= 1'b0;
      else if (por_q_ff && !por_active)
         in_system_programming_mode <= !p1_sync[2]; // R6
   end

   //======================================================================
   // Port 1 bits 2 and 3, open-drain or input-only per p1_od_en
   logic [1:0] nxt_p1_oe;
   logic [1:0] p1_oe_ff;

   always_comb
   begin
      nxt_p1_oe = '0;
      if (rst_act)
         nxt_p1_oe = '0; // R12
      else if (i2c_en)
      begin
         nxt_p1_oe[port_pin_pkg::P1_SCL] = !scl_out; // R3 R13
         nxt_p1_oe[port_pin_pkg::P1_SDA] = !sda_out; // R3 R13
      end
      else
      begin
         if (t0_out_en)
            nxt_p1_oe[port_pin_pkg::P1_SCL] = !t0_out_val; // R2 R13
         else
            nxt_p1_oe[0] = p1_od_en[0] && !p1_latch[0]; // R1 R12
         nxt_p1_oe[1] = p1_od_en[1] && !p1_latch[1]; // R1 R12
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         p1_oe_ff <= '0;
      else
         p1_oe_ff <= nxt_p1_oe;
   end

   // These pads can only sink current, so the driven level is always low.
   assign port1_bit2_out = 1'b0; // R1
   assign port1_bit3_out = 1'b0; // R1
   assign port1_bit2_oe  = p1_oe_ff[0];
   assign port1_bit3_oe  = p1_oe_ff[1];

   //======================================================================
   // Inputs handed to the port readers and peripherals
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         p1_pin_val         <= '0;
         p2_pin_val         <= '0;
         timer_zero_pin     <= 1'b0;
         ext_irq_zero_input <= 1'b0;
         scl_in             <= 1'b0;
         sda_in             <= 1'b0;
      end
      else
      begin
         p1_pin_val         <= p1_sync; // R4
         p2_pin_val         <= p2_sync;
         timer_zero_pin     <= p1_sync[0]; // R2
         ext_irq_zero_input <= p1_sync[1]; // R3
         scl_in             <= p1_sync[0]; // R3
         sda_in             <= p1_sync[1]; // R3
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         mosi_in              <= 1'b0;
         miso_in              <= 1'b0;
         sel_n_in             <= 1'b1;
         spi_serial_clock_pad <= 1'b0;
      end
      else
      begin
         mosi_in              <= p2_sync[port_pin_pkg::P2_MOSI]; // R9
         miso_in              <= p2_sync[port_pin_pkg::P2_MISO]; // R10
         sel_n_in             <= p2_sync[port_pin_pkg::P2_SEL]; // R11
         spi_serial_clock_pad <= p2_sync[port_pin_pkg::P2_SCK]; // R11
      end
   end

   //======================================================================
   // Port 2 alternate function selection
   logic [3:0] alt_own;
   logic [3:0] alt_drv;
   logic [3:0] alt_val;

   always_comb
   begin
      alt_own = {4{spi_en && !rst_act}}; // R13
      alt_drv = '0;
      alt_val = '0;
      alt_drv[port_pin_pkg::P2_MOSI] = spi_master; // R9
      alt_val[port_pin_pkg::P2_MOSI] = mosi_out;
      alt_drv[port_pin_pkg::P2_MISO] = !spi_master; // R10
      alt_val[port_pin_pkg::P2_MISO] = miso_out;
      alt_drv[port_pin_pkg::P2_SEL]  = 1'b0; // R11
      alt_drv[port_pin_pkg::P2_SCK]  = spi_master; // R11
      alt_val[port_pin_pkg::P2_SCK]  = sck_out;
   end

   //======================================================================
   // Port 2 per-pin output type and drive
   genvar gi;
   generate
      for (gi = 0; gi < port_pin_pkg::P2_W; gi++)
      begin : g_p2
         port_pin_pkg::port_mode_e mode_ff;
         port_pin_pkg::port_mode_e eff_mode;
         logic                     eff_val;
         logic                     d_out;
         logic                     d_oe;
         logic                     d_pu;

         // Output type is held at input-only through reset.
         always_ff @(posedge sys_clk)
         begin
            if (rst_act)
               mode_ff <= port_pin_pkg::MODE_RST; // R7
            else
               mode_ff <= port_pin_pkg::port_mode_e'(
                          p2_mode[gi*port_pin_pkg::MODE_W +: port_pin_pkg::MODE_W]); // R8
         end

         always_comb
         begin
            if (alt_own[gi])
            begin
               eff_mode = alt_drv[gi] ? port_pin_pkg::mode_push_pull
                                      : port_pin_pkg::mode_input_only; // R13
               eff_val  = alt_val[gi];
            end
            else
            begin
               eff_mode = mode_ff; // R8
               eff_val  = p2_latch[gi];
            end
         end

         pad_drive u_drive
         (
            .mode (eff_mode),
            .val  (eff_val),
            .out  (d_out),
            .oe   (d_oe),
            .pu   (d_pu)
         );

         always_ff @(posedge sys_clk)
         begin
            if (rst_act)
            begin
               port2_pad_out[gi] <= 1'b0; // R7
               port2_pad_oe[gi]  <= 1'b0; // R7
               port2_pad_pu[gi]  <= 1'b0; // R7
            end
            else
            begin
               port2_pad_out[gi] <= d_out;
               port2_pad_oe[gi]  <= d_oe;
               port2_pad_pu[gi]  <= d_pu;
            end
         end
      end
   endgenerate

   //======================================================================
   // Checks
   sequence pad_reset_seen;
      nrst && rst_sel && !p1_sync[2];
   endsequence
   sequence por_release_low;
      por_active ##1 (!por_active && !p1_sync[2]);
   endsequence
   sequence spi_steady(logic m);
      (spi_en && spi_master == m && !rst_act) [*2];
   endsequence

   p1_open_drain_a: assert property ( // R1
      @(posedge sys_clk) disable iff (!nrst)
      (!rst_act && !i2c_en && !t0_out_en && p1_latch[0])
      |=> !port1_bit2_oe && !port1_bit2_out)
      else $error("Port 1 bit 2 driven while latch high.");
   t0_overflow_a: assert property ( // R2
      @(posedge sys_clk) disable iff (!nrst)
      (!rst_act && !i2c_en && t0_out_en) |=> port1_bit2_oe == !$past(t0_out_val))
      else $error("Timer 0 overflow not routed to pad.");
   i2c_pull_a: assert property ( // R3
      @(posedge sys_clk) disable iff (!nrst)
      (!rst_act && i2c_en && !sda_out) |=> port1_bit3_oe)
      else $error("I2C data low not driven.");
   pad_reset_a: assert property ( // R5
      @(posedge sys_clk) disable iff (!nrst)
      pad_reset_seen |=> !dev_rst_n_ff)
      else $error("Reset pad low did not reset.");
   isp_entry_a: assert property ( // R6
      @(posedge sys_clk) disable iff (!nrst)
      por_release_low |=> in_system_programming_mode)
      else $error("Programming mode not entered.");
   reset_input_a: assert property ( // R7
      @(posedge sys_clk) disable iff (!nrst)
      rst_act |=> (port2_pad_oe == 4'h0 && port2_pad_pu == 4'h0 && !port1_bit3_oe))
      else $error("Pin left driving during reset.");
   mosi_dir_a: assert property ( // R9
      @(posedge sys_clk) disable iff (!nrst)
      spi_steady(1'b1) |=> port2_pad_oe[port_pin_pkg::P2_MOSI]
                        && !port2_pad_oe[port_pin_pkg::P2_MISO])
      else $error("MOSI or MISO direction wrong as master.");
   miso_dir_a: assert property ( // R10
      @(posedge sys_clk) disable iff (!nrst)
      spi_steady(1'b0) |=> port2_pad_oe[port_pin_pkg::P2_MISO]
                        && !port2_pad_oe[port_pin_pkg::P2_MOSI])
      else $error("MISO or MOSI direction wrong as slave.");
   sck_dir_a: assert property ( // R11
      @(posedge sys_clk) disable iff (!nrst)
      (spi_en && !rst_act) |=> port2_pad_oe[port_pin_pkg::P2_SCK] == $past(spi_master)
                            && !port2_pad_oe[port_pin_pkg::P2_SEL])
      else $error("SPI clock or select direction wrong.");
   mode_follow_a: assert property ( // R8
      @(posedge sys_clk) disable iff (!nrst)
      (!rst_act && !spi_en && p2_mode[1:0] == 2'h1) [*2] |=>
      port2_pad_oe[0] && port2_pad_out[0] == $past(p2_latch[0]))
      else $error("Push-pull pin not following latch.");
endmodule

// ---- board_model.sv ----
// Board-side model of the shared pads: pull-ups, outside drivers and the reset line.
`timescale 1ns/1ps
module board_model
(
   // Clock
   input  wire logic       sys_clk,
   // Pad controls from the device
   input  wire logic [1:0] p1_oe,
   input  wire logic [1:0] p1_out,
   input  wire logic [3:0] p2_oe,
   input  wire logic [3:0] p2_out,
   input  wire logic [3:0] p2_pu,
   // Commands from the bench
   input  wire logic [1:0] ext_low,
   input  wire logic [3:0] ext_en,
   input  wire logic [3:0] ext_val,
   input  wire logic       rst_level,
   // Pad levels
   output logic      [1:0] p1_pad,
   output logic      [3:0] p2_pad,
   output logic            rst_pad
);
   logic toggle_ff = 1'b0;

   always @(posedge sys_clk)
   begin
      toggle_ff <= ~toggle_ff;
   end

   //======================================================================
   // Pad resolution
   // Port 1 lines are open-drain with board pull-ups, so anyone pulling low wins.
   // A port 2 line nobody drives and without pull-up shows a changing value,
   // so a stale level can never pass for a good read.
   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         p1_pad[i] = ~((p1_oe[i] & ~p1_out[i]) | ext_low[i]);
      end
      for (int i = 0; i < 4; i++)
      begin
         if (p2_oe[i])
            p2_pad[i] = p2_out[i];
         else if (ext_en[i])
            p2_pad[i] = ext_val[i];
         else
            p2_pad[i] = p2_pu[i] | toggle_ff;
      end
      rst_pad = rst_level;
   end
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the port pin function multiplexer.
`timescale 1ns/1ps
module tb_top;
   logic       sys_clk = 1'b0;
   logic       nrst, por_active, dev_rst_n_ff, in_system_programming_mode;
   logic [7:0] user_config_byte_one, p2_mode;
   logic       port1_bit2_out, port1_bit2_oe, port1_bit3_out, port1_bit3_oe;
   logic [3:0] port2_pad_out, port2_pad_oe, port2_pad_pu, p2_latch, p2_pin_val;
   logic [1:0] p1_latch, p1_od_en, p1_pad, ext_low;
   logic [2:0] p1_pin_val;
   logic       t0_out_en, t0_out_val, timer_zero_pin, ext_irq_zero_input;
   logic       i2c_en, scl_out, sda_out, scl_in, sda_in, rst_level, rst_pad;
   logic       spi_en, spi_master, mosi_out, miso_out, sck_out;
   logic       mosi_in, miso_in, sel_n_in, spi_serial_clock_pad;
   logic [3:0] p2_pad, ext_en, ext_val;
   port_pin_pkg::port_mode_e m;
   int         err_count = 0;
   int         total_checks = 0;
   int         cycles = 0;

   always #4 sys_clk = ~sys_clk;

   port_pin_function_mux port_pin_function_mux_inst
   (
      .sys_clk, .nrst, .por_active, .user_config_byte_one, .dev_rst_n_ff,
      .in_system_programming_mode, .port1_bit2_in(p1_pad[0]), .port1_bit2_out,
      .port1_bit2_oe, .port1_bit3_in(p1_pad[1]), .port1_bit3_out, .port1_bit3_oe,
      .port1_bit5_in(rst_pad), .port2_pad_in(p2_pad), .port2_pad_out, .port2_pad_oe,
      .port2_pad_pu, .p1_latch, .p1_od_en, .p1_pin_val, .p2_latch, .p2_mode, .p2_pin_val,
      .t0_out_en, .t0_out_val, .timer_zero_pin, .ext_irq_zero_input, .i2c_en, .scl_out,
      .sda_out, .scl_in, .sda_in, .spi_en, .spi_master, .mosi_out, .miso_out, .sck_out,
      .mosi_in, .miso_in, .sel_n_in, .spi_serial_clock_pad
   );

   board_model board_model_inst
   (
      .sys_clk, .p1_oe({port1_bit3_oe, port1_bit2_oe}),
      .p1_out({port1_bit3_out, port1_bit2_out}), .p2_oe(port2_pad_oe),
      .p2_out(port2_pad_out), .p2_pu(port2_pad_pu), .ext_low, .ext_en, .ext_val,
      .rst_level, .p1_pad, .p2_pad, .rst_pad
   );

   //======================================================================
   // Helpers
   function automatic logic exp_oe(input port_pin_pkg::port_mode_e md, input logic l);
      case (md)
         port_pin_pkg::mode_push_pull:  return 1'b1;
         port_pin_pkg::mode_input_only: return 1'b0;
         default:                       return ~l;
      endcase
   endfunction

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Six edges cover the slowest path, a mode change seen back through the synchronisers.
   task automatic settle(input int n = 6);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         err_count++;
         close_out();
      end
   end

   //======================================================================
   // Main sequence
   initial
   begin
      void'($urandom(32'h73ae));
      nrst = 1'b0; por_active = 1'b0; user_config_byte_one = 8'h00;
      p1_latch = 2'h0; p1_od_en = 2'h3; p2_latch = 4'h0; p2_mode = 8'h55;
      t0_out_en = 1'b0; t0_out_val = 1'b0; i2c_en = 1'b0; scl_out = 1'b1;
      sda_out = 1'b1; spi_en = 1'b0; spi_master = 1'b0; mosi_out = 1'b0;
      miso_out = 1'b0; sck_out = 1'b0; ext_low = 2'h0; ext_en = 4'hf;
      ext_val = 4'h5; rst_level = 1'b1;
      settle(5);
      chk({port2_pad_oe, port2_pad_pu}, 8'h00);
      chk({port1_bit3_oe, port1_bit2_oe}, 8'h00);
      chk(dev_rst_n_ff, 8'h00);
      @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (16)
      begin
         @(posedge sys_clk);
         p1_latch <= 2'($urandom);
         p1_od_en <= 2'($urandom);
         rst_level <= 1'($urandom);
         settle();
         chk({port1_bit3_oe, port1_bit2_oe}, p1_od_en & ~p1_latch);
         chk({port1_bit3_out, port1_bit2_out}, 8'h00);
         chk(p1_pin_val, {rst_level, 2'(~(p1_od_en & ~p1_latch))});
         chk(dev_rst_n_ff, 8'h01);
      end
      for (int v = 0; v < 3; v++)
      begin
         @(posedge sys_clk);
         p1_latch <= 2'h3;
         t0_out_en <= (v < 2);
         t0_out_val <= v[0];
         ext_low <= {1'b0, v == 2};
         settle();
         chk(port1_bit2_oe, v == 0);
         chk(timer_zero_pin, v == 1);
      end
      for (int v = 0; v < 4; v++)
      begin
         @(posedge sys_clk);
         p1_latch <= 2'h0;
         ext_low <= 2'h0;
         i2c_en <= 1'b1;
         t0_out_en <= 1'b1;
         t0_out_val <= 1'b0;
         scl_out <= v[0];
         sda_out <= v[1];
         settle();
         chk({port1_bit3_oe, port1_bit2_oe}, 2'(~v[1:0]));
         chk({ext_irq_zero_input, sda_in, scl_in}, {v[1], v[1:0]});
      end
      @(posedge sys_clk);
      i2c_en <= 1'b0;
      t0_out_en <= 1'b0;
      repeat (20)
      begin
         @(posedge sys_clk);
         p2_mode <= 8'($urandom);
         p2_latch <= 4'($urandom);
         ext_val <= 4'($urandom);
         ext_en <= 4'($urandom);
         settle();
         for (int i = 0; i < 4; i++)
         begin
            m = port_pin_pkg::port_mode_e'(p2_mode[2*i+:2]);
            chk(port2_pad_oe[i], exp_oe(m, p2_latch[i]));
            if (port2_pad_oe[i] === 1'b1)
               chk(port2_pad_out[i], m == port_pin_pkg::mode_push_pull && p2_latch[i]);
            if (m == port_pin_pkg::mode_quasi || m == port_pin_pkg::mode_input_only)
               chk(port2_pad_pu[i], m == port_pin_pkg::mode_quasi);
            if (m == port_pin_pkg::mode_input_only && ext_en[i])
               chk(p2_pin_val[i], ext_val[i]);
         end
      end
      for (int v = 0; v < 4; v++)
      begin
         @(posedge sys_clk);
         spi_en <= 1'b1;
         spi_master <= v[0];
         p2_mode <= 8'h55;
         ext_en <= 4'hf;
         ext_val <= 4'($urandom);
         mosi_out <= 1'($urandom);
         miso_out <= 1'($urandom);
         sck_out <= 1'($urandom);
         settle();
         chk(port2_pad_oe, v[0] ? 4'h9 : 4'h2);
         if (v[0])
            chk({port2_pad_out[3], port2_pad_out[0], miso_in}, {sck_out, mosi_out, ext_val[1]});
         else
            chk({port2_pad_out[1], spi_serial_clock_pad, sel_n_in, mosi_in},
                {miso_out, ext_val[3:2], ext_val[0]});
      end
      for (int v = 0; v < 2; v++)
      begin
         @(posedge sys_clk);
         user_config_byte_one <= {7'h00, !v[0]};
         por_active <= v[0];
         p1_od_en <= 2'h3;
         p1_latch <= 2'h0;
         rst_level <= 1'b0;
         settle();
         chk(dev_rst_n_ff, 8'h00);
         chk({port2_pad_oe, port2_pad_pu}, 8'h00);
         chk({port1_bit3_oe, port1_bit2_oe}, 8'h00);
         @(posedge sys_clk);
         por_active <= 1'b0;
         user_config_byte_one <= 8'h00;
         settle();
         chk(in_system_programming_mode, v[0]);
         chk(dev_rst_n_ff, 8'h01);
         @(posedge sys_clk);
         rst_level <= 1'b1;
      end
      @(posedge sys_clk);
      nrst <= 1'b0;
      por_active <= 1'b1;
      settle();
      chk(in_system_programming_mode, 8'h00);
      @(posedge sys_clk);
      nrst <= 1'b1;
      // The reset pad is high, so no pad reset may follow the release.
      settle(2);
      chk(dev_rst_n_ff, 8'h01);
      settle(4);
      @(posedge sys_clk);
      por_active <= 1'b0;
      settle();
      chk({in_system_programming_mode, dev_rst_n_ff}, 8'h01);
      close_out();
   end
endmodule
